// ---- design/background_debug.sv ----
// Background debug command interpreter: hardware and firmware commands
`timescale 1ns/1ps
module background_debug (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic debug_wire_pin_in,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [15:0] tx_word,
   input wire logic cpu_bus_free,
   input wire logic cpu_boundary,
   input wire logic tag_hit,
   input wire logic [7:0] cpu_condition_code_reg,
   output logic cpu_freeze,
   output logic cpu_resume,
   output logic cpu_step,
   output logic mem_req,
   output logic mem_we,
   output logic [1:0] mem_be,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_bd_map,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic fw_req,
   output logic fw_write,
   output logic [2:0] fw_reg_sel,
   output logic [15:0] fw_wdata,
   input wire logic fw_done,
   input wire logic [15:0] fw_rdata,
   input wire logic periph_mode,
   input wire logic par_we,
   input wire logic [7:0] par_wdata,
   output logic [7:0] par_rdata,
   output logic background_active
);
   logic [7:0] debug_instruction;
   logic [7:0] debug_status;
   logic [15:0] debug_shift_word;
   logic [15:0] debug_address_word;
   logic [7:0] saved_condition_codes;
   debug_pkg::cmd_state_t state;
   logic cmd_write;
   logic cmd_word;
   logic cmd_bd_map;
   logic cmd_firmware;
   logic bg_pending;
   logic pin_sync;
   logic pin_prev;
   logic host_fall;
   logic idle_expired;
   logic steal_due;
   logic is_internal;
   logic [15:0] internal_word;
   logic [15:0] aligned_addr;
   logic [15:0] access_data;
   logic [1:0] lanes;
   logic in_range_fw;
   logic fw_is_read;
   logic cmd_start;
   logic status_write;
   logic [7:0] status_wdata;
   logic ccr_write;
   logic [7:0] ccr_wdata;
   logic go_cmd;
   logic step_cmd;
   logic tag_cmd;

   // ****************************************************************
   // Host edge watch and idle timeout
   // ****************************************************************
   sync_two_flop #(.WIDTH(1)) pin_sync_inst (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(debug_wire_pin_in),
      .sync_out(pin_sync)
   );

   // Edge is taken from the settled copy only
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         pin_prev <= 1'b1;
      else
         pin_prev <= pin_sync;
   end

   assign host_fall = pin_prev && !pin_sync;

   // Timer restarts on expiry, so the timeout is a single-cycle event
   // and the first byte after a long silence is not swallowed by it
   cycle_limit #(.LIMIT(debug_pkg::IDLE_TIMEOUT_CYCLES)) idle_inst (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clear(host_fall || idle_expired),
      .run(1'b1),
      .reached(idle_expired)
   );

   // Waiting for a free bus cycle; the count starts over per access
   cycle_limit #(.LIMIT(debug_pkg::STEAL_LIMIT_CYCLES)) steal_inst (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clear(state != debug_pkg::S_ACCESS),
      .run(!cpu_bus_free),
      .reached(steal_due)
   );

   // ****************************************************************
   // Command decode and address helpers
   // ****************************************************************
   // Word accesses drop address bit 0 so they are always aligned
   assign aligned_addr = cmd_word ? {debug_address_word[15:1], 1'b0}
                                  : debug_address_word;
   // Lane 1 is the even (high) byte, lane 0 the odd (low) byte
   assign lanes = cmd_word ? 2'b11
                : (debug_address_word[0] ? 2'b01 : 2'b10);
   // Status byte is always reachable so the host can enable background mode;
   // the other debug registers only appear while active
   assign is_internal = cmd_bd_map
      && (debug_address_word[15:3] == debug_pkg::INSTR_ADDR[15:3])
      && (debug_address_word <= debug_pkg::CCR_ADDR)
      && (debug_status[debug_pkg::ST_ACTIVE]
          || debug_address_word == debug_pkg::STATUS_ADDR);
   assign cmd_start = (state == debug_pkg::S_IDLE) && rx_valid;
   assign in_range_fw = (rx_byte >= debug_pkg::OP_FW_RD_FIRST
                         && rx_byte <= debug_pkg::OP_FW_RD_LAST)
                     || (rx_byte >= debug_pkg::OP_FW_WR_FIRST
                         && rx_byte <= debug_pkg::OP_FW_WR_LAST);
   assign fw_is_read = rx_byte[5];
   // Go, step and tag commands need an active background mode; the enable bit is not checked
   assign go_cmd = cmd_start && rx_byte == debug_pkg::OP_GO
                   && background_active;
   assign step_cmd = cmd_start && rx_byte == debug_pkg::OP_STEP
                     && background_active;
   assign tag_cmd = cmd_start && rx_byte == debug_pkg::OP_TAG_AND_RESUME
                    && background_active;

   // Byte data is placed on its lane, the other lane reads zero
   always_comb
   begin
      case (aligned_addr[2:1])
         2'b00: internal_word = {debug_instruction, debug_status};
         2'b01: internal_word = debug_shift_word;
         2'b10: internal_word = debug_address_word;
         default: internal_word = {saved_condition_codes, 8'h00};
      endcase
      access_data = {lanes[1] ? internal_word[15:8] : 8'h00,
                     lanes[0] ? internal_word[7:0] : 8'h00};
   end

   // Mapped writes that land on the status or condition code bytes
   always_comb
   begin
      status_write = 1'b0;
      status_wdata = debug_shift_word[7:0];
      ccr_write = 1'b0;
      ccr_wdata = debug_shift_word[15:8];
      if (state == debug_pkg::S_ACCESS && is_internal && cmd_write)
      begin
         if (aligned_addr[2:1] == 2'b00 && lanes[0])
            status_write = 1'b1;
         if (aligned_addr[2:1] == 2'b11 && lanes[1])
            ccr_write = 1'b1;
      end
   end

   // ****************************************************************
   // Command sequencer
   // ****************************************************************
   // One state walk per command; a host timeout abandons a partial one
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state <= debug_pkg::S_IDLE;
         cmd_write <= 1'b0;
         cmd_word <= 1'b0;
         cmd_bd_map <= 1'b0;
         cmd_firmware <= 1'b0;
         debug_address_word <= debug_pkg::WORD_RESET;
         debug_shift_word <= debug_pkg::WORD_RESET;
         mem_req <= 1'b0;
         fw_req <= 1'b0;
         tx_valid <= 1'b0;
         cpu_freeze <= 1'b0;
      end
      else if (idle_expired && state != debug_pkg::S_MEM_WAIT
               && state != debug_pkg::S_IDLE)
      begin
         // Memory handshakes are never cut off midway
         state <= debug_pkg::S_IDLE;
         fw_req <= 1'b0;
         tx_valid <= 1'b0;
         cpu_freeze <= 1'b0;
      end
      else
      begin
         fw_req <= 1'b0;
         case (state)
            debug_pkg::S_IDLE:
            begin
               if (rx_valid)
               begin
                  cmd_write <= !rx_byte[5];
                  cmd_word <= rx_byte[3];
                  cmd_bd_map <= rx_byte[2];
                  cmd_firmware <= !rx_byte[7];
                  fw_reg_sel <= rx_byte[2:0];
                  case (rx_byte)
                     debug_pkg::OP_RD_BD_BYTE, debug_pkg::OP_RD_BD_WORD,
                     debug_pkg::OP_RD_BYTE, debug_pkg::OP_RD_WORD,
                     debug_pkg::OP_WR_BD_BYTE, debug_pkg::OP_WR_BD_WORD,
                     debug_pkg::OP_WR_BYTE, debug_pkg::OP_WR_WORD:
                        state <= debug_pkg::S_ADDR_HI;
                     default:
                     begin
                        if (in_range_fw && background_active)
                           state <= fw_is_read ? debug_pkg::S_FW_CALL
                                    : debug_pkg::S_DATA_HI;
                        else
                           state <= debug_pkg::S_IDLE;
                     end
                  endcase
               end
            end
            debug_pkg::S_ADDR_HI:
               if (rx_valid)
               begin
                  debug_address_word[15:8] <= rx_byte;
                  state <= debug_pkg::S_ADDR_LO;
               end
            debug_pkg::S_ADDR_LO:
               if (rx_valid)
               begin
                  debug_address_word[7:0] <= rx_byte;
                  state <= cmd_write ? debug_pkg::S_DATA_HI
                           : debug_pkg::S_ACCESS;
               end
            debug_pkg::S_DATA_HI:
               if (rx_valid)
               begin
                  debug_shift_word[15:8] <= rx_byte;
                  state <= debug_pkg::S_DATA_LO;
               end
            debug_pkg::S_DATA_LO:
               if (rx_valid)
               begin
                  debug_shift_word[7:0] <= rx_byte;
                  state <= cmd_firmware ? debug_pkg::S_FW_CALL
                           : debug_pkg::S_ACCESS;
               end
            debug_pkg::S_ACCESS:
            begin
               if (is_internal)
               begin
                  // Register bytes answer at once, no CPU bus needed
                  if (!cmd_write)
                  begin
                     debug_shift_word <= access_data;
                     tx_valid <= 1'b1;
                     state <= debug_pkg::S_SEND;
                  end
                  else
                     state <= debug_pkg::S_IDLE;
               end
               else if (cpu_bus_free || steal_due)
               begin
                  mem_req <= 1'b1;
                  mem_we <= cmd_write;
                  mem_be <= lanes;
                  mem_addr <= aligned_addr;
                  mem_bd_map <= cmd_bd_map
                                && background_active;
                  mem_wdata <= debug_shift_word;
                  cpu_freeze <= steal_due;
                  state <= debug_pkg::S_MEM_WAIT;
               end
            end
            debug_pkg::S_MEM_WAIT:
            begin
               if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  cpu_freeze <= 1'b0;
                  if (!cmd_write)
                  begin
                     debug_shift_word <= {
                        mem_be[1] ? mem_rdata[15:8] : 8'h00,
                        mem_be[0] ? mem_rdata[7:0] : 8'h00};
                     tx_valid <= 1'b1;
                     state <= debug_pkg::S_SEND;
                  end
                  else
                     state <= debug_pkg::S_IDLE;
               end
               else
                  cpu_freeze <= 1'b1;
            end
            debug_pkg::S_FW_CALL:
            begin
               fw_req <= !fw_req && !fw_done;
               fw_write <= cmd_write;
               fw_wdata <= debug_shift_word;
               if (fw_done)
               begin
                  if (!cmd_write)
                  begin
                     debug_shift_word <= fw_rdata;
                     tx_valid <= 1'b1;
                     state <= debug_pkg::S_SEND;
                  end
                  else
                     state <= debug_pkg::S_IDLE;
               end
            end
            debug_pkg::S_SEND:
               if (tx_ready)
               begin
                  tx_valid <= 1'b0;
                  state <= debug_pkg::S_IDLE;
               end
            default:
               state <= debug_pkg::S_IDLE;
         endcase
      end
   end

   // Data output follows the shift word one cycle late, so it settles a cycle after tx_valid rises
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         tx_word <= debug_pkg::WORD_RESET;
      else
         tx_word <= debug_shift_word;
   end

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   // A fresh opcode wins over the timeout and the parallel port
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         debug_instruction <= debug_pkg::INSTR_RESET;
      else if (cmd_start)
         debug_instruction <= rx_byte;
      else if (idle_expired)
         debug_instruction <= debug_pkg::INSTR_RESET;
      else if (periph_mode && par_we)
         debug_instruction <= par_wdata;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         par_rdata <= debug_pkg::INSTR_RESET;
      else
         par_rdata <= periph_mode ? debug_instruction : 8'h00;
   end

   // ****************************************************************
   // Status, mode entry and exit
   // ****************************************************************
   // Hardware events are applied after a host write so they win
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         debug_status <= debug_pkg::STATUS_RESET;
         bg_pending <= 1'b0;
         cpu_resume <= 1'b0;
         cpu_step <= 1'b0;
      end
      else
      begin
         cpu_resume <= go_cmd || tag_cmd;
         cpu_step <= step_cmd;
         if (status_write)
            debug_status[debug_pkg::ST_ENABLE]
               <= status_wdata[debug_pkg::ST_ENABLE];
         if (cmd_start && rx_byte == debug_pkg::OP_BACKGROUND)
            // Dropped while active so a later resume does not re-enter
            bg_pending <= debug_status[debug_pkg::ST_ENABLE]
                          && !debug_status[debug_pkg::ST_ACTIVE];
         if (go_cmd || step_cmd || tag_cmd)
            debug_status[debug_pkg::ST_ACTIVE] <= 1'b0;
         if (step_cmd)
            debug_status[debug_pkg::ST_TRACE] <= 1'b1;
         if (tag_cmd)
            debug_status[debug_pkg::ST_TAG] <= 1'b1;
         if (state == debug_pkg::S_FW_CALL && fw_done && !cmd_write)
            debug_status[debug_pkg::ST_SDV] <= 1'b1;
         else if (state == debug_pkg::S_SEND && tx_ready)
            debug_status[debug_pkg::ST_SDV] <= 1'b0;
         // Entry needs the enable bit; otherwise the CPU carries on
         if (debug_status[debug_pkg::ST_ENABLE]
             && !debug_status[debug_pkg::ST_ACTIVE]
             && ((cpu_boundary && (bg_pending
                  || debug_status[debug_pkg::ST_TRACE]))
                 || (tag_hit && debug_status[debug_pkg::ST_TAG])))
         begin
            debug_status[debug_pkg::ST_ACTIVE] <= 1'b1;
            debug_status[debug_pkg::ST_TAG] <= 1'b0;
            debug_status[debug_pkg::ST_TRACE] <= 1'b0;
            bg_pending <= 1'b0;
         end
      end
   end

   // Condition codes are captured on entry unless the host writes them
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         saved_condition_codes <= debug_pkg::CCR_RESET;
      else if (ccr_write)
         saved_condition_codes <= ccr_wdata;
      else if (!background_active && debug_status[debug_pkg::ST_ACTIVE])
         saved_condition_codes <= cpu_condition_code_reg;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         background_active <= 1'b0;
      else
         background_active <= debug_status[debug_pkg::ST_ACTIVE];
   end
endmodule

// ---- design/debug_pkg.sv ----
// Shared constants for the background debug command interpreter
package debug_pkg;
   // ****************************************************************
   // Debug register map
   // ****************************************************************
   localparam logic [15:0] INSTR_ADDR = 16'hff00;
   localparam logic [15:0] STATUS_ADDR = 16'hff01;
   localparam logic [15:0] SHIFT_ADDR = 16'hff02;
   localparam logic [15:0] ADDRESS_ADDR = 16'hff04;
   localparam logic [15:0] CCR_ADDR = 16'hff06;
   localparam logic [15:0] ROM_FIRST = 16'hff20;
   localparam logic [15:0] ROM_LAST = 16'hffff;
   localparam logic [7:0] INSTR_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] CCR_RESET = 8'h00;
   // Status bit positions
   localparam int ST_ENABLE = 7;
   localparam int ST_ACTIVE = 6;
   localparam int ST_TAG = 5;
   localparam int ST_SDV = 4;
   localparam int ST_TRACE = 3;

   // ****************************************************************
   // Opcodes
   // ****************************************************************
   localparam logic [7:0] OP_BACKGROUND = 8'h90;
   localparam logic [7:0] OP_RD_BD_BYTE = 8'he4;
   localparam logic [7:0] OP_RD_BD_WORD = 8'hec;
   localparam logic [7:0] OP_RD_BYTE = 8'he0;
   localparam logic [7:0] OP_RD_WORD = 8'he8;
   localparam logic [7:0] OP_WR_BD_BYTE = 8'hc4;
   localparam logic [7:0] OP_WR_BD_WORD = 8'hcc;
   localparam logic [7:0] OP_WR_BYTE = 8'hc0;
   localparam logic [7:0] OP_WR_WORD = 8'hc8;
   localparam logic [7:0] OP_FW_RD_FIRST = 8'h62;
   localparam logic [7:0] OP_FW_RD_LAST = 8'h67;
   localparam logic [7:0] OP_FW_WR_FIRST = 8'h42;
   localparam logic [7:0] OP_FW_WR_LAST = 8'h47;
   localparam logic [7:0] OP_GO = 8'h08;
   localparam logic [7:0] OP_STEP = 8'h10;
   localparam logic [7:0] OP_TAG_AND_RESUME = 8'h18;

   // ****************************************************************
   // Timing, in E-clock cycles (one sys_clk cycle each)
   // ****************************************************************
   localparam int IDLE_TIMEOUT_CYCLES = 512;
   localparam int STEAL_LIMIT_CYCLES = 128;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_ADDR_HI = 4'b0001,
      S_ADDR_LO = 4'b0010,
      S_DATA_HI = 4'b0011,
      S_DATA_LO = 4'b0100,
      S_ACCESS = 4'b0101,
      S_MEM_WAIT = 4'b0110,
      S_FW_CALL = 4'b0111,
      S_SEND = 4'b1000
   } cmd_state_t;
endpackage

// ---- design/sync_two_flop.sv ----
// Two flip-flop synchroniser for signals arriving from outside sys_clk
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] first_stage;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         first_stage <= '1;
         sync_out <= '1;
      end
      else
      begin
         first_stage <= async_in;
         sync_out <= first_stage;
      end
   end
endmodule

// ---- design/cycle_limit.sv ----
// Saturating cycle counter that flags when a limit is reached
`timescale 1ns/1ps
module cycle_limit #(
   parameter int LIMIT = 128,
   parameter int WIDTH = $clog2(LIMIT + 1)
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic run,
   output logic reached
);
   localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT);
   logic [WIDTH-1:0] count;

   // Clear has priority so a fresh event always restarts the span
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         count <= '0;
      else if (clear)
         count <= '0;
      else if (run && count != LAST)
         count <= count + WIDTH'(1);
   end

   assign reached = (count == LAST);
endmodule

// ---- tb/debug_checker_sva.sv ----
// Port checker for the background debug command interpreter
`timescale 1ns/1ps
module debug_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [15:0] tx_word,
   input wire logic mem_req,
   input wire logic mem_ack,
   input wire logic [1:0] mem_be,
   input wire logic [15:0] mem_addr,
   input wire logic cpu_freeze,
   input wire logic cpu_resume,
   input wire logic fw_req,
   input wire logic background_active,
   input wire logic periph_mode,
   input wire logic [7:0] par_rdata
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // Answers and bus requests must hold until taken
   property p_tx_hold;
      tx_valid && $past(tx_valid) && !tx_ready
         |=> tx_valid && $stable(tx_word);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("answer dropped");
   property p_req_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("req dropped");
   property p_thaw;
      mem_ack |=> !cpu_freeze;
   endproperty
   a_thaw: assert property (p_thaw) else $error("freeze stuck");
   property p_fw_pulse;
      fw_req |=> !fw_req;
   endproperty
   a_fw_pulse: assert property (p_fw_pulse) else $error("fw long");
   // Firmware may only be called while the CPU sits in background
   property p_fw_active;
      fw_req |-> background_active;
   endproperty
   a_fw_active: assert property (p_fw_active) else $error("fw idle");
   property p_even;
      mem_req && mem_be == 2'b11 |-> !mem_addr[0];
   endproperty
   a_even: assert property (p_even) else $error("odd word");
   property p_exit;
      cpu_resume |-> ##[1:3] !background_active;
   endproperty
   a_exit: assert property (p_exit) else $error("no exit");
   property p_par_off;
      !periph_mode |=> par_rdata == 8'h00;
   endproperty
   a_par_off: assert property (p_par_off) else $error("par leak");
endmodule
bind background_debug debug_checker chk_i (.*);

// ---- tb/host_pod.sv ----
// Debug host pod model: sends command bytes and takes answer words
`timescale 1ns/1ps
module host_pod (
   input wire logic sys_clk,
   input wire logic tx_valid,
   input wire logic [15:0] tx_word,
   output logic debug_wire_pin_in = 1'b1,
   output logic rx_valid = 1'b0,
   output logic [7:0] rx_byte = 8'h00,
   output logic tx_ready = 1'b0
);
   // Pin falls with each byte so the device idle timer restarts
   task automatic put(input logic [7:0] b);
      @(negedge sys_clk);
      debug_wire_pin_in = 1'b0;
      rx_valid = 1'b1;
      rx_byte = b;
      @(negedge sys_clk);
      debug_wire_pin_in = 1'b1;
      rx_valid = 1'b0;
      rx_byte = ~b;
   endtask
   // Host settles 150 cycles after each answer before going on
   task automatic get(output logic [15:0] w);
      int n;
      n = 0;
      while (tx_valid !== 1'b1 && n < 400)
      begin
         @(negedge sys_clk);
         n++;
      end
      repeat (2) @(negedge sys_clk);
      w = tx_valid === 1'b1 ? tx_word : 16'hxxxx;
      tx_ready = 1'b1;
      @(negedge sys_clk);
      tx_ready = 1'b0;
      repeat (150) @(negedge sys_clk);
   endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the background debug command interpreter
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic debug_wire_pin_in, rx_valid, tx_ready, tx_valid, cpu_freeze;
   logic cpu_resume, cpu_step, mem_req, mem_we, mem_bd_map, fw_req;
   logic fw_write, par_we, background_active, periph_mode, cpu_boundary;
   logic cpu_bus_free, mem_ack, fw_done;
   logic tag_hit = 1'b0;
   logic [7:0] cpu_condition_code_reg = 8'h5c;
   logic [7:0] rx_byte, par_rdata;
   logic [7:0] par_wdata = 8'h3c;
   logic [1:0] mem_be;
   logic [2:0] fw_reg_sel;
   logic [15:0] tx_word, mem_addr, mem_wdata, fw_wdata, w, wa;
   logic [15:0] mem_rdata, fw_rdata;
   // Small word store; the tests touch only a few addresses
   logic [15:0] mem [16];
   int bad_count = 0;
   int comparisons = 0;
   int n;
   background_debug dut (.*);
   host_pod pod (.*);
   assign wa = {mem_addr[15:1], 1'b0};
   always #5 sys_clk = ~sys_clk;
   // Bus and firmware responders; answer one cycle after a request
   always @(negedge sys_clk)
   begin
      cpu_boundary <= ~cpu_boundary;
      mem_ack <= mem_req && !mem_ack;
      fw_done <= fw_req;
      fw_rdata <= {13'h0a50, fw_reg_sel};
      mem_rdata <= mem[wa[4:1]];
      if (mem_req && !mem_ack && mem_we && mem_be[1])
         mem[wa[4:1]][15:8] <= mem_wdata[15:8];
      if (mem_req && !mem_ack && mem_we && mem_be[0])
         mem[wa[4:1]][7:0] <= mem_wdata[7:0];
   end
   task automatic chk(input string s, input logic [15:0] e,
         input logic [15:0] v);
      comparisons++;
      if (v !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int k = 0,
         input logic [15:0] a = 16'h0000, input logic [15:0] d = 16'h0000);
      pod.put(op);
      for (int j = 0; j < k; j++)
      begin
         pod.put(j ? d[15:8] : a[15:8]);
         pod.put(j ? d[7:0] : a[7:0]);
      end
   endtask
   // Bounded wait for a design strobe, cycles waited in n
   task automatic hunt(ref logic s);
      n = 0;
      while (s !== 1'b1 && n < 300)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Whole run needs some 3400 cycles; a hang is cut well after that
   initial
   begin
      #200000;
      bad_count++;
      give_verdict();
   end
   initial
   begin
      {periph_mode, cpu_bus_free, cpu_boundary, par_we} = 4'hc;
      {mem_ack, fw_done, mem_rdata, fw_rdata} = 34'h0;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      par_we = 1'b1;
      @(negedge sys_clk);
      par_we = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("par", 16'h003c, 16'(par_rdata));
      cmd(8'he8);
      repeat (2) @(negedge sys_clk);
      chk("instr", 16'h00e8, 16'(par_rdata));
      repeat (530) @(negedge sys_clk);
      chk("clear", 16'h0000, 16'(par_rdata));
      periph_mode = 1'b0;
      // Word write, then a byte write landing on the odd lane
      cmd(8'hc8, 2, 16'h2001, 16'habcd);
      hunt(mem_req);
      chk("wa", 16'h2000, mem_addr);
      chk("wc", 16'h0007, {12'h000, mem_bd_map, mem_we, mem_be});
      chk("wd", 16'habcd, mem_wdata);
      repeat (150) @(negedge sys_clk);
      cmd(8'hc0, 2, 16'h2001, 16'h1234);
      repeat (150) @(negedge sys_clk);
      cmd(8'he0, 1, 16'h2001);
      pod.get(w);
      chk("rlo", 16'h0034, w);
      // Busy CPU: the access must steal a cycle and freeze it
      cpu_bus_free = 1'b0;
      cmd(8'he8, 1, 16'h2000);
      hunt(mem_req);
      chk("steal", 16'h0003, {14'h0, cpu_freeze, n > 120});
      cpu_bus_free = 1'b1;
      pod.get(w);
      chk("rw", 16'hab34, w);
      cmd(8'h90);
      repeat (20) @(negedge sys_clk);
      chk("noact", 16'h0000, 16'(background_active));
      cmd(8'hc4, 2, 16'hff01, 16'h0080);
      repeat (150) @(negedge sys_clk);
      cmd(8'h90);
      hunt(background_active);
      chk("act", 16'h0001, 16'(background_active));
      cmd(8'he4, 1, 16'hff01);
      pod.get(w);
      chk("stat", 16'h00c0, w & 16'hffe0);
      cmd(8'he4, 1, 16'hff06);
      pod.get(w);
      chk("ccr", 16'h5c00, w);
      for (int i = 0; i < 6; i++)
      begin
         cmd(8'h62 + 8'(i));
         hunt(fw_req);
         chk("frs", 16'(i + 2), {12'h000, fw_write, fw_reg_sel});
         pod.get(w);
         chk("frd", {13'h0a50, 3'(i + 2)}, w);
         cmd(8'h42 + 8'(i), 1, 16'h1100 + 16'(i));
         hunt(fw_req);
         chk("fws", 16'(i + 10), {12'h000, fw_write, fw_reg_sel});
         chk("fwd", 16'h1100 + 16'(i), fw_wdata);
         repeat (40) @(negedge sys_clk);
      end
      cmd(8'h10);
      hunt(cpu_step);
      repeat (64) @(negedge sys_clk);
      chk("step", 16'h0001, 16'(n < 300 && background_active));
      cmd(8'h77);
      repeat (20) @(negedge sys_clk);
      chk("unk", 16'h0001, {14'h0, mem_req, background_active});
      for (int i = 0; i < 2; i++)
      begin
         cmd(8'h90);
         hunt(background_active);
         cmd(i ? 8'h18 : 8'h08);
         hunt(cpu_resume);
         repeat (64) @(negedge sys_clk);
         chk("go", 16'h0001, 16'(n < 300 && !background_active));
      end
      // Tag armed by the last resume: a tagged instruction re-enters
      tag_hit = 1'b1;
      @(negedge sys_clk);
      tag_hit = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("tag", 16'h0001, 16'(background_active));
      give_verdict();
   end
endmodule
